// file: hw/tli_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module tli_ctrl #(
	parameter int NUM_SRC = tli_pkg::NUM_SRC
) (
	input  wire logic                    mclk,
	input  wire logic                    resetn,
	input  wire logic [7:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	input  wire logic [NUM_SRC-1:0]      src_event,
	input  wire logic                    cpu_instr_done,
	input  wire logic                    return_from_isr_instr,
	output logic                         irq_req,
	output logic                         long_call_instr,
	output logic [tli_pkg::VEC_W-1:0]    call_vector,
	output logic [1:0]                   in_service
);
	import tli_pkg::*;

	localparam int EXT_W = NUM_SRC - BASE_EN_W;

	// The extended enable register needs at least one extended source; status word and vector packing need each index to fit in IDX_W bits
	initial begin
		if (NUM_SRC <= BASE_EN_W || NUM_SRC > (1 << IDX_W) || NUM_SRC >= 32) begin
			$error("NUM_SRC out of range for this controller");
		end
	end

	// Expand byte enables into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{be[b]}};
		end
		return m;
	endfunction

	// Merge write data into a register through the lane mask
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [31:0] m);
		return (old_v & ~m) | (new_v & m);
	endfunction

	tli_state_t          state;
	tli_state_t          next_state;
	logic [7:0]          irq_enable_reg;
	logic [EXT_W-1:0]    ext_enable;
	logic [NUM_SRC-1:0]  prio;
	logic [NUM_SRC-1:0]  pend;
	logic [NUM_SRC-1:0]  next_pend;
	logic [2:0]          call_cnt;
	logic                ack_q;
	logic [IDX_W-1:0]    last_idx;
	logic                call_high;

	// Bus slave decode: one wait cycle, then the access completes
	wire                 bus_req   = avs_read | avs_write;
	wire                 wr_fire   = avs_write & ack_q;
	wire                 rd_sample = avs_read & ~ack_q;
	wire [31:0]          wmask     = lane_mask(avs_byteenable);
	wire                 hit_en    = wr_fire & (avs_address == OFF_ENABLE);
	wire                 hit_ext   = wr_fire & (avs_address == OFF_EXT_ENABLE);
	wire                 hit_prio  = wr_fire & (avs_address == OFF_PRIORITY);
	wire                 hit_pend  = wr_fire & (avs_address == OFF_PENDING);

	assign avs_waitrequest = bus_req & ~ack_q;

	// Enables: global bit gates every per-source bit
	wire                 global_irq_enable = irq_enable_reg[GLOBAL_EN_BIT];
	wire [NUM_SRC-1:0]   src_enable = {ext_enable, irq_enable_reg[BASE_EN_W-1:0]};
	wire [NUM_SRC-1:0]   active = pend & src_enable & {NUM_SRC{global_irq_enable}};

	// Preemption window: low may preempt nothing, high only a low routine
	wire                 allow_hi = ~in_service[1];
	wire                 allow_lo = (in_service == 2'b00);

	wire                 arb_valid;
	wire [IDX_W-1:0]     arb_idx;
	wire                 arb_high;

	tli_arbiter #(
		.N  (NUM_SRC),
		.IW (IDX_W)
	) u_arb (
		.mclk        (mclk),
		.resetn      (resetn),
		.active      (active),
		.prio        (prio),
		.allow_hi    (allow_hi),
		.allow_lo    (allow_lo),
		.grant_valid (arb_valid),
		.grant_idx   (arb_idx),
		.grant_high  (arb_high)
	);

	// A call is taken only at an instruction boundary after one detect cycle;
	// the return itself is not a boundary, so one more instruction must run
	wire                 st_run = (state == ST_RUN);
	wire                 take = st_run & cpu_instr_done & irq_req & arb_valid;
	wire [VEC_W-1:0]     next_vector = VEC_BASE +
	                     {{(VEC_W-IDX_W-VEC_SHIFT){1'b0}}, arb_idx, {VEC_SHIFT{1'b0}}};
	wire [NUM_SRC-1:0]   take_onehot = take ? (NUM_SRC'(1) << arb_idx) : '0;
	wire [NUM_SRC-1:0]   hw_clear = take_onehot & HW_CLEAR_MASK[NUM_SRC-1:0];

	// Pending update: hardware events win over any clear in the same cycle
	wire [31:0]          pend_wr = merge(PEND_RESET | 32'(pend), avs_writedata, wmask);
	always_comb begin
		next_pend = pend;
		if (hit_pend) begin
			next_pend = pend_wr[NUM_SRC-1:0];
		end
		next_pend = (next_pend & ~hw_clear) | src_event;
	end

	// Call sequencer: the core is busy for the call cycles after a take
	always_comb begin
		case (state)
			ST_RUN: begin
				next_state = take ? ST_CALL : ST_RUN;
			end
			ST_CALL: begin
				next_state = (call_cnt == 3'h1) ? ST_RUN : ST_CALL;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// Read data mux, reserved bits read as zero
	wire [31:0]          rd_status = {{(24-IDX_W){1'b0}}, last_idx, 4'h0,
	                                  state == ST_CALL, irq_req, in_service};
	wire [31:0]          rd_mux =
		(avs_address == OFF_ENABLE)     ? {24'h00_0000, irq_enable_reg} :
		(avs_address == OFF_EXT_ENABLE) ? 32'(ext_enable) :
		(avs_address == OFF_PRIORITY)   ? 32'(prio) :
		(avs_address == OFF_PENDING)    ? 32'(pend) :
		(avs_address == OFF_STATUS)     ? rd_status : 32'h0000_0000;

	wire [31:0]          en_wr   = merge({24'h00_0000, irq_enable_reg}, avs_writedata, wmask);
	wire [31:0]          ext_wr  = merge(32'(ext_enable), avs_writedata, wmask);
	wire [31:0]          prio_wr = merge(32'(prio), avs_writedata, wmask);

	// Bus handshake and read data
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (rd_sample) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	// Software configuration registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_enable_reg <= ENABLE_RESET;
			ext_enable     <= EXT_EN_RESET[EXT_W-1:0];
			prio           <= PRIO_RESET[NUM_SRC-1:0];
		end else begin
			if (hit_en) begin
				irq_enable_reg <= en_wr[7:0];
			end
			if (hit_ext) begin
				ext_enable <= ext_wr[EXT_W-1:0];
			end
			if (hit_prio) begin
				prio <= prio_wr[NUM_SRC-1:0];
			end
		end
	end

	// Pending flags, sampled every cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pend <= PEND_RESET[NUM_SRC-1:0];
		end else begin
			pend <= next_pend;
		end
	end

	// Detect stage: one registered cycle between flag and request
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= arb_valid;
		end
	end

	// Call strobe and vector
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			long_call_instr <= 1'b0;
			call_vector     <= '0;
			call_high       <= 1'b0;
			last_idx        <= '0;
		end else begin
			long_call_instr <= take;
			if (take) begin
				call_vector <= next_vector;
				call_high   <= arb_high;
				last_idx    <= arb_idx;
			end
		end
	end

	// Sequencer state and call cycle count
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state    <= ST_RUN;
			call_cnt <= 3'h0;
		end else begin
			state <= next_state;
			if (take) begin
				call_cnt <= CALL_CYCLES;
			end else if (call_cnt != 3'h0) begin
				call_cnt <= call_cnt - 3'h1;
			end
		end
	end

	// Levels in service; a return closes the most recent, i.e. highest, level,
	// which brings a preempted low routine back to the foreground
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			in_service <= 2'b00;
		end else begin
			if (return_from_isr_instr) begin
				if (in_service[1]) begin
					in_service[1] <= 1'b0;
				end else begin
					in_service[0] <= 1'b0;
				end
			end
			// A call in the cycle of a return still opens its level; set wins
			if (take) begin
				if (arb_high) begin
					in_service[1] <= 1'b1;
				end else begin
					in_service[0] <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_event_sets_flag: assert property ((src_event != '0) |=>
		(pend & $past(src_event)) == $past(src_event))
		else $error("source event did not set pending flag");
	a_req_needs_enable: assert property (irq_req |->
		$past(global_irq_enable) && ($past(pend & src_enable) != '0))
		else $error("request raised without enabled pending flag");
	a_global_blocks: assert property (!global_irq_enable [*2] |-> !irq_req)
		else $error("request raised while global enable clear");
	a_call_at_boundary: assert property (long_call_instr |->
		$past(cpu_instr_done) && $past(irq_req))
		else $error("call not at instruction boundary");
	a_vector_value: assert property (long_call_instr |->
		call_vector == VEC_BASE + (VEC_W'(last_idx) << VEC_SHIFT) && call_vector <= VEC_LAST)
		else $error("vector does not match granted source");
	a_no_call_at_return: assert property (return_from_isr_instr |=> !long_call_instr)
		else $error("call issued on the return instruction");
	a_high_not_preempted: assert property (long_call_instr |-> !$past(in_service[1], 2))
		else $error("high routine preempted");
	a_low_only_by_high: assert property (long_call_instr && $past(in_service[0], 2) |->
		call_high)
		else $error("low routine preempted by low request");
	a_call_spacing: assert property (long_call_instr |=> !long_call_instr [*5])
		else $error("second call inside call cycles");
	a_prio_reset_low: assert property ($rose(resetn) |-> prio == '0)
		else $error("priorities not low after reset");
	a_hw_clear: assert property (take |=>
		(pend & $past(hw_clear & ~src_event)) == '0)
		else $error("self-clearing flag survived the call");
	a_sw_set: assert property (hit_pend && (avs_writedata[NUM_SRC-1:0] & wmask[NUM_SRC-1:0]) != '0
		|=> (pend & $past(avs_writedata[NUM_SRC-1:0] & wmask[NUM_SRC-1:0] & ~hw_clear))
		== $past(avs_writedata[NUM_SRC-1:0] & wmask[NUM_SRC-1:0] & ~hw_clear))
		else $error("software set of pending flag lost");


	// Bus slave, level bookkeeping, request and call sequencer checks
	a_wait_single: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait cycle on the bus");
	a_low_waits_idle: assert property (long_call_instr && !call_high |-> $past(in_service) == 2'b00)
		else $error("low call while a routine was running");
	a_level_set: assert property (long_call_instr |-> (call_high ? in_service[1] : in_service[0]))
		else $error("call did not mark its level in service");
	a_return_top: assert property (return_from_isr_instr && in_service[1] && !take |=> !in_service[1])
		else $error("return left the high level in service");
	a_return_low: assert property (return_from_isr_instr && in_service == 2'b01 && !take
		|=> in_service == 2'b00)
		else $error("return left the low level in service");
	a_disabled_quiet: assert property ((active == '0) |=> !irq_req)
		else $error("request raised with no enabled pending flag");
	a_req_tracks: assert property (arb_valid |=> irq_req)
		else $error("eligible source not requested next cycle");
	a_count_range: assert property (call_cnt <= CALL_CYCLES)
		else $error("call counter beyond call length");
	a_call_busy: assert property (long_call_instr |-> state == ST_CALL)
		else $error("call strobe outside call sequence");

	c_global_gate: cover property (hit_en ##[1:20] long_call_instr);
	c_call_low: cover property (long_call_instr && !call_high);
	c_preempt: cover property (long_call_instr && call_high && $past(in_service[0], 2));
	c_return_retake: cover property (return_from_isr_instr ##[1:20] long_call_instr);
	c_sw_event: cover property (hit_pend ##[1:20] long_call_instr);
endmodule

// file: hw/tli_pkg.sv
package tli_pkg;

	// Source count and widths
	localparam int NUM_SRC     = 19;
	localparam int IDX_W       = 5;
	localparam int VEC_W       = 16;
	localparam int BASE_EN_W   = 7;
	localparam int GLOBAL_EN_BIT = 7;

	// Vector layout: base plus index times eight
	localparam logic [15:0] VEC_BASE     = 16'h0003;
	localparam int          VEC_SHIFT    = 3;
	localparam logic [15:0] VEC_LAST     = 16'h0093;

	// Cycles the core spends on the long call
	localparam logic [2:0]  CALL_CYCLES  = 3'h5;

	// Register byte offsets on the Avalon slave
	localparam logic [7:0]  OFF_ENABLE     = 8'h00;
	localparam logic [7:0]  OFF_EXT_ENABLE = 8'h04;
	localparam logic [7:0]  OFF_PRIORITY   = 8'h08;
	localparam logic [7:0]  OFF_PENDING    = 8'h0C;
	localparam logic [7:0]  OFF_STATUS     = 8'h10;

	// Reset values
	localparam logic [7:0]  ENABLE_RESET   = 8'h00;
	localparam logic [31:0] EXT_EN_RESET   = 32'h0000_0000;
	localparam logic [31:0] PRIO_RESET     = 32'h0000_0000;
	localparam logic [31:0] PEND_RESET     = 32'h0000_0000;

	// Sources whose flag the block clears itself when the call is made
	localparam logic [31:0] HW_CLEAR_MASK  = 32'h0000_000F;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_CALL = 2'b10
	} tli_state_t;

endpackage

// file: hw/tli_arbiter.sv
`timescale 1ns/100ps
module tli_arbiter #(
	parameter int N  = tli_pkg::NUM_SRC,
	parameter int IW = tli_pkg::IDX_W
) (
	input  wire logic          mclk,
	input  wire logic          resetn,
	input  wire logic [N-1:0]  active,
	input  wire logic [N-1:0]  prio,
	input  wire logic          allow_hi,
	input  wire logic          allow_lo,
	output logic               grant_valid,
	output logic [IW-1:0]      grant_idx,
	output logic               grant_high
);
	import tli_pkg::*;

	// Lowest set index wins inside a level
	function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
		logic [IW-1:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IW'(i);
			end
		end
		return r;
	endfunction

	logic [N-1:0] req_hi;
	logic [N-1:0] req_lo;
	wire          any_hi;
	wire          any_lo;

	// Split requests by level and gate by what may preempt now
	for (genvar g = 0; g < N; g++) begin : g_split
		assign req_hi[g] = active[g] & prio[g] & allow_hi;
		assign req_lo[g] = active[g] & ~prio[g] & allow_lo;
	end

	assign any_hi      = |req_hi;
	assign any_lo      = |req_lo;
	assign grant_valid = any_hi | any_lo;
	assign grant_high  = any_hi;
	assign grant_idx   = any_hi ? first_set(req_hi) : first_set(req_lo);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_high_beats_low: assert property ((|req_hi) |-> grant_high && prio[grant_idx])
		else $error("low level granted while high request present");
	a_fixed_order: assert property (grant_valid |->
		((grant_high ? req_hi : req_lo) & ((N'(1) << grant_idx) - N'(1))) == '0)
		else $error("grant skipped an earlier source of same level");
endmodule

// file: testbench/tli_core_model.sv
`timescale 1ns/100ps
// Core stand-in: paces instructions, stalls for the call, issues returns on command
module tli_core_model (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic slow,
	input  wire logic ret_cmd,
	input  wire logic long_call_instr,
	output logic      cpu_instr_done,
	output logic      return_from_isr_instr
);
	logic [2:0] quiet;
	logic [1:0] phase;

	// The call occupies five cycles; a return is never also an instruction boundary
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			quiet                 <= 3'h0;
			phase                 <= 2'h0;
			cpu_instr_done        <= 1'b0;
			return_from_isr_instr <= 1'b0;
		end else begin
			phase                 <= phase + 2'h1;
			quiet                 <= long_call_instr ? 3'h5 : (quiet != 3'h0 ? quiet - 3'h1 : 3'h0);
			return_from_isr_instr <= ret_cmd;
			cpu_instr_done        <= !long_call_instr && quiet <= 3'h1 && !ret_cmd
			                         && (!slow || phase == 2'h0);
		end
	end
endmodule

// file: testbench/tli_ctrl_tb_top.sv
`timescale 1ns/100ps
module tli_ctrl_tb_top;
	import tli_pkg::*;
	logic        mclk;
	logic        resetn;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [18:0] src_event;
	logic        cpu_instr_done;
	logic        return_from_isr_instr;
	logic        irq_req;
	logic        long_call_instr;
	logic [15:0] call_vector;
	logic [1:0]  in_service;
	logic        slow;
	logic        ret_cmd;
	int          errors;
	int          checks_done;
	int          cyc;
	int          k;
	int          t;
	int          a;
	int          b;
	logic [15:0] vq[$];
	int          tq[$];

	tli_ctrl i_tli_ctrl (
		.mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.src_event(src_event), .cpu_instr_done(cpu_instr_done),
		.return_from_isr_instr(return_from_isr_instr), .irq_req(irq_req),
		.long_call_instr(long_call_instr), .call_vector(call_vector), .in_service(in_service)
	);
	tli_core_model i_tli_core_model (
		.mclk(mclk), .resetn(resetn), .slow(slow), .ret_cmd(ret_cmd),
		.long_call_instr(long_call_instr), .cpu_instr_done(cpu_instr_done),
		.return_from_isr_instr(return_from_isr_instr)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Log every call with its cycle, so bus traffic never hides one
	always @(posedge mclk) begin
		if (long_call_instr === 1'b1) begin
			vq.push_back(call_vector);
			tq.push_back(cyc);
		end
		cyc <= cyc + 1;
	end

	function automatic logic [15:0] vec(input int i);
		return VEC_BASE + (16'(i) << VEC_SHIFT);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One Avalon access; holds everything until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address   <= ad;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50) errors++;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, q);
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] q);
		bus(1'b0, ad, 32'h0, q);
	endtask

	task automatic pulse(input int i);
		@(posedge mclk);
		src_event <= 19'h00001 << i;
		k = cyc;
		@(posedge mclk);
		src_event <= 19'h00000;
	endtask

	task automatic ret();
		@(posedge mclk);
		ret_cmd <= 1'b1;
		@(posedge mclk);
		ret_cmd <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic wait_call(input logic [15:0] exp, output int tc);
		int n;
		n = 0;
		while (vq.size() == 0 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		tc = (tq.size() != 0) ? tq.pop_front() : -1;
		chk({16'h0, (vq.size() != 0) ? vq.pop_front() : 16'hFFFF}, {16'h0, exp});
	endtask

	task automatic no_call(input int n);
		repeat (n) @(posedge mclk);
		chk(32'(vq.size()), 32'h0);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Guard against a hang well past the expected run length
	initial begin
		#(4 * 20000);
		errors++;
		close_out();
	end

	initial begin
		logic [31:0] q;
		logic [31:0] prio;
		int          lo;
		int          hi;
		errors = 0;
		checks_done = 0;
		cyc = 0;
		resetn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		src_event = 19'h00000;
		slow = 1'b0;
		ret_cmd = 1'b0;
		void'($urandom(66673));
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		// Reset values, last address unmapped
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), q);
			chk(q, 32'h0);
		end
		$display("test 1 done");
		// Flag set while everything is disabled, serviced once enabled
		pulse(5);
		rd(OFF_PENDING, q);
		chk(q, 32'h0000_0020);
		chk({31'h0, irq_req}, 32'h0);
		wr(OFF_ENABLE, 32'h0000_0020);
		no_call(10);
		chk({31'h0, irq_req}, 32'h0);
		wr(OFF_ENABLE, 32'h0000_00A0);
		wait_call(vec(5), t);
		chk({30'h0, in_service}, 32'h1);
		ret();
		wait_call(vec(5), t);
		wr(OFF_PENDING, 32'h0);
		ret();
		no_call(20);
		chk({30'h0, in_service}, 32'h0);
		$display("test 2 done");
		// Fastest path and a self-clearing flag
		wr(OFF_ENABLE, 32'h0000_0084);
		pulse(2);
		wait_call(vec(2), t);
		chk(32'(t - k), 32'h4);
		rd(OFF_PENDING, q);
		chk(q, 32'h0);
		ret();
		$display("test 3 done");
		// Random pairs raised by software: fixed order, then high level first
		wr(OFF_EXT_ENABLE, 32'h0000_0FFF);
		for (int i = 0; i < 8; i++) begin
			a = $urandom_range(18, 0);
			b = (a + 1 + $urandom_range(17, 0)) % 19;
			lo = (a < b) ? a : b;
			hi = (a < b) ? b : a;
			prio = i[0] ? (32'h1 << hi) : 32'h0;
			slow <= i[1];
			wr(OFF_ENABLE, 32'h0);
			wr(OFF_PRIORITY, prio);
			wr(OFF_PENDING, (32'h1 << a) | (32'h1 << b));
			wr(OFF_ENABLE, 32'h0000_00FF);
			wait_call(vec(i[0] ? hi : lo), t);
			chk({30'h0, in_service}, i[0] ? 32'h2 : 32'h1);
			wr(OFF_PENDING, 32'h0);
			ret();
		end
		slow <= 1'b0;
		$display("test 4 done");
		// Preemption of low by high, none of high
		wr(OFF_PRIORITY, 32'h0000_0202);
		pulse(7);
		wait_call(vec(7), t);
		pulse(9);
		wait_call(vec(9), t);
		chk({30'h0, in_service}, 32'h3);
		pulse(1);
		no_call(30);
		wr(OFF_PENDING, 32'h0);
		ret();
		chk({30'h0, in_service}, 32'h1);
		ret();
		no_call(10);
		chk({30'h0, in_service}, 32'h0);
		$display("test 5 done");
		close_out();
	end
endmodule
